// ### shared/branch_bitset_pkg.sv
package branch_bitset_pkg;
  localparam int          INSTR_W           = 16;
  localparam int          PC_W              = 21;
  localparam logic [7:0]  OPC_BR_NO_OVF     = 8'h0_0E5;
  localparam logic [7:0]  OPC_BR_NONZERO    = 8'h0_0E1;
  localparam logic [4:0]  OPC_BR_UNCOND     = 5'h0_01A;
  localparam logic [3:0]  OPC_SET_BIT       = 4'h0_008;
  localparam int          PC_STEP           = 2;
  localparam logic [1:0]  Q_RESET           = 2'h0_000;
  localparam logic [20:0] PC_RESET          = 21'h00_0000;
  localparam logic [3:0]  BANK_RESET        = 4'h0_000;
  localparam logic [3:0]  ACCESS_HI_BANK    = 4'h0_00F;
  localparam logic [7:0]  ACCESS_SPLIT      = 8'h0_060;

  typedef enum logic [1:0]
  {
    PH_Q1 = 2'b00,
    PH_Q2 = 2'b01,
    PH_Q3 = 2'b11,
    PH_Q4 = 2'b10
  } phase_t;
endpackage : branch_bitset_pkg

// ### rtl/bank_addr_gen.sv
`timescale 1ns/1ps
`default_nettype none
module bank_addr_gen
  import branch_bitset_pkg::*;
(
  // operand fields
  input  wire logic       i_bank_sel,
  input  wire logic [7:0] i_file_addr,
  input  wire logic [3:0] i_bank,
  // full data address
  output logic      [11:0] o_addr
);
  // access bank: low part in bank 0, upper part maps to the special register bank
  always_comb
  begin
    if (i_bank_sel)
      o_addr = {i_bank, i_file_addr};
    else if (i_file_addr < ACCESS_SPLIT)
      o_addr = {4'h0_000, i_file_addr};
    else
      o_addr = {ACCESS_HI_BANK, i_file_addr};
  end
endmodule : bank_addr_gen
`default_nettype wire

// ### rtl/branch_bitset_exec.sv
`timescale 1ns/1ps
`default_nettype none
// How it works
// - opcode high byte E5 branches by a signed 8-bit offset when overflow is clear.
// - opcode high byte E1 branches by a signed 8-bit offset when zero is clear.
// - a taken branch loads the incremented pc plus twice the signed offset.
// - a conditional branch costs one cycle untaken and two taken, the second idle.
// - decode in Q1, read offset in Q2, process in Q3, write pc in Q4 only if taken.
// - top bits 11010 decode as an unconditional branch with an 11-bit signed offset.
// - the unconditional branch always adds twice its offset and always takes two cycles.
// - top nibble 1000 sets bit b of register f, with a bank bit a.
// - none of these operations changes any status flag.
// - a clear selects the access bank, a set uses the bank select register.
module branch_bitset_exec
  import branch_bitset_pkg::*;
#(
  parameter int ADDR_W = PC_W
)
(
  // clock and reset
  input  wire logic               i_clk,
  input  wire logic               i_rst_b,
  // instruction supply
  input  wire logic [INSTR_W-1:0] i_instr,
  input  wire logic               i_instr_valid,
  // status flags and bank select register
  input  wire logic               i_ovf,
  input  wire logic               i_zero,
  input  wire logic [3:0]         i_bank_select_register,
  // data memory read path
  input  wire logic [7:0]         i_rd_data,
  // phase and pc
  output logic      [1:0]         o_phase,
  output logic      [ADDR_W-1:0]  o_pc,
  output logic                    o_fetch,
  output logic                    o_busy,
  // data memory access
  output logic      [11:0]        o_mem_addr,
  output logic                    o_mem_rd,
  output logic                    o_mem_wr,
  output logic      [7:0]         o_wr_data,
  // flags are never written
  output logic                    o_flags_we
);
  // the doubled 11-bit offset must fit in the pc, so narrower pcs are refused
  if (ADDR_W < 12)
  begin : g_addr_w_check
    $error("pc too narrow for branch offsets");
  end

  phase_t              phase_q, phase_d;
  logic [ADDR_W-1:0]   pc_q, pc_d;
  logic                idle_q, idle_d;
  logic [INSTR_W-1:0]  ir_q, ir_d;
  logic [ADDR_W-1:0]   off_q, off_d;
  logic                take_q, take_d;
  logic [7:0]          data_q, data_d;
  logic                is_nov, is_nz, is_bra, is_set;
  logic [11:0]         addr;
  logic [ADDR_W-1:0]   off8, off11;
  logic [ADDR_W-1:0]   target;

  // instruction class; every other opcode falls to no operation
  typedef enum logic [2:0]
  {
    OP_NONE    = 3'b000,
    OP_NO_OVF  = 3'b001,
    OP_NONZERO = 3'b011,
    OP_UNCOND  = 3'b010,
    OP_SET_BIT = 3'b110
  } op_t;

  op_t op;

  always_comb
  begin
    if (ir_q[15:8] == OPC_BR_NO_OVF)
      op = OP_NO_OVF;
    else if (ir_q[15:8] == OPC_BR_NONZERO)
      op = OP_NONZERO;
    else if (ir_q[15:11] == OPC_BR_UNCOND)
      op = OP_UNCOND;
    else if (ir_q[15:12] == OPC_SET_BIT)
      op = OP_SET_BIT;
    else
      op = OP_NONE;
  end

  assign is_nov = op == OP_NO_OVF;
  assign is_nz  = op == OP_NONZERO;
  assign is_bra = op == OP_UNCOND;
  assign is_set = op == OP_SET_BIT;
  // doubled, sign-extended offsets
  assign off8  = ADDR_W'({{(ADDR_W-9){ir_q[7]}}, ir_q[7:0], 1'b0});
  assign off11 = ADDR_W'({{(ADDR_W-12){ir_q[10]}}, ir_q[10:0], 1'b0});
  // pc already points past the branch, so this lands on pc + 2 + 2n
  assign target = pc_q + off_q;

  bank_addr_gen u_bank
  (
    .i_bank_sel  (ir_q[8]),
    .i_file_addr (ir_q[7:0]),
    .i_bank      (i_bank_select_register),
    .o_addr      (addr)
  );

  // phase sequencer: one phase per clock edge, Gray order around the cycle
  always_comb
  begin
    case (phase_q)
      PH_Q1:   phase_d = PH_Q2;
      PH_Q2:   phase_d = PH_Q3;
      PH_Q3:   phase_d = PH_Q4;
      PH_Q4:   phase_d = PH_Q1;
      default: phase_d = PH_Q1;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      phase_q <= phase_t'(Q_RESET);
    else
      phase_q <= phase_d;
  end

  always_comb
  begin
    pc_d    = pc_q;
    idle_d  = idle_q;
    ir_d    = ir_q;
    off_d   = off_q;
    take_d  = take_q;
    data_d  = data_q;
    case (phase_q)
      PH_Q1:
      begin
        // the instruction was latched at the previous Q4; decode here
        take_d = 1'b0;
      end
      PH_Q2:
      begin
        if (!idle_q)
        begin
          if (is_nov || is_nz)
            off_d = off8;
          else if (is_bra)
            off_d = off11;
          if (is_set)
            data_d = i_rd_data;
        end
      end
      PH_Q3:
      begin
        if (!idle_q)
        begin
          // condition evaluated in process phase
          take_d = (is_nov && !i_ovf) || (is_nz && !i_zero) || is_bra;
          if (is_set)
            data_d = data_q | (8'h0_001 << ir_q[11:9]);
        end
      end
      PH_Q4:
      begin
        // a taken branch refuses the word on offer, so the next cycle runs idle
        if (!idle_q && take_q)
        begin
          pc_d   = target;
          idle_d = 1'b1;
        end
        else
        begin
          idle_d = 1'b0;
          if (i_instr_valid)
          begin
            ir_d = i_instr;
            pc_d = pc_q + ADDR_W'(PC_STEP);
          end
          else
          begin
            // a missing word becomes 0000, which decodes to no operation
            ir_d = '0;
          end
        end
      end
      default:
      begin
        take_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      pc_q    <= ADDR_W'(PC_RESET);
      idle_q  <= 1'b1;
      ir_q    <= '0;
      off_q   <= '0;
      take_q  <= 1'b0;
      data_q  <= '0;
    end
    else
    begin
      pc_q    <= pc_d;
      idle_q  <= idle_d;
      ir_q    <= ir_d;
      off_q   <= off_d;
      take_q  <= take_d;
      data_q  <= data_d;
    end
  end

  assign o_phase    = phase_q;
  assign o_pc       = pc_q;
  assign o_fetch    = (phase_q == PH_Q4) && !(take_q && !idle_q);
  assign o_busy     = idle_q;
  assign o_mem_addr = addr;
  assign o_mem_rd   = (phase_q == PH_Q2) && !idle_q && is_set;
  assign o_mem_wr   = (phase_q == PH_Q4) && !idle_q && is_set;
  assign o_wr_data  = data_q;
  assign o_flags_we = 1'b0;
endmodule : branch_bitset_exec
`default_nettype wire

// ### verification/bbx_checker.sv
`timescale 1ns/1ps
`default_nettype none
module bbx_checker
  import branch_bitset_pkg::*;
#(parameter int ADDR_W = PC_W)
(
  // clock and reset
  input wire logic              i_clk,
  input wire logic              i_rst_b,
  // watched outputs
  input wire logic [1:0]        o_phase,
  input wire logic [ADDR_W-1:0] o_pc,
  input wire logic              o_fetch,
  input wire logic              o_busy,
  input wire logic              o_mem_rd,
  input wire logic              o_mem_wr,
  input wire logic              o_flags_we
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  chk_flags_kept: assert property (o_flags_we == 1'b0)
    else $error("flag write seen");
  chk_phase_wrap: assert property (o_phase == PH_Q4 |=> o_phase == PH_Q1)
    else $error("phase did not wrap");
  chk_read_q2: assert property (o_mem_rd |-> o_phase == PH_Q2)
    else $error("read outside Q2");
  chk_read_write: assert property (o_mem_rd |-> ##2 o_mem_wr)
    else $error("no write back");
  chk_fetch_q4: assert property (o_fetch |-> o_phase == PH_Q4)
    else $error("fetch outside Q4");
  chk_pc_hold: assert property (o_phase != PH_Q4 |=> $stable(o_pc))
    else $error("pc moved early");
  chk_idle_cycle: assert property (o_phase == PH_Q4 && !o_fetch |=> o_busy [*4])
    else $error("idle cycle short");
  chk_idle_ends: assert property (o_busy && o_phase == PH_Q4 |-> o_fetch)
    else $error("idle cycle too long");
  chk_idle_quiet: assert property (o_busy |-> !o_mem_rd && !o_mem_wr)
    else $error("access in idle cycle");
  cover property (o_mem_wr);
  cover property (o_phase == PH_Q4 && !o_fetch);
  cover property (o_fetch ##4 o_fetch);
endmodule : bbx_checker
bind branch_bitset_exec bbx_checker #(.ADDR_W(ADDR_W)) chk (.*);
`default_nettype wire

// ### verification/prog_mem.sv
`timescale 1ns/1ps
`default_nettype none
module prog_mem
  import branch_bitset_pkg::*;
(
  input  wire logic [PC_W-1:0] i_pc,
  output logic      [15:0]     o_word,
  output logic                 o_valid
);
  localparam logic [15:0] ROM [8] = '{16'he103, 16'h0000, 16'h8e10, 16'h0000,
                                      16'he505, 16'h8b34, 16'h8070, 16'hd7f9};
  // outside the program the word is the inverted pc and valid is low, so a stale value never looks valid
  always_comb
  begin
    o_valid = i_pc < 21'h10;
    o_word  = o_valid ? ROM[i_pc[3:1]] : ~i_pc[15:0];
  end
endmodule : prog_mem
`default_nettype wire

// ### verification/test_relative_branch_and_bit_set_decode.sv
`timescale 1ns/1ps
`default_nettype none
module test_relative_branch_and_bit_set_decode import branch_bitset_pkg::*; ;
  logic            i_clk = 0, i_rst_b = 0, i_instr_valid, i_ovf = 1, i_zero = 0;
  logic [15:0]     i_instr;
  logic [3:0]      i_bank_select_register = 0;
  logic [7:0]      i_rd_data = 0, o_wr_data;
  logic [1:0]      o_phase;
  logic [PC_W-1:0] o_pc;
  logic            o_fetch, o_busy, o_mem_rd, o_mem_wr, o_flags_we;
  logic [11:0]     o_mem_addr;
  logic [PC_W-1:0] pq[$];
  logic [19:0]     wq[$];
  int              fails = 0, n_tests = 0;
  branch_bitset_exec dut (.*);
  prog_mem mem (.i_pc(o_pc), .o_word(i_instr), .o_valid(i_instr_valid));
  initial forever #10 i_clk = ~i_clk;
  task automatic check(logic [31:0] seen, logic [31:0] want);
    n_tests++;
    if (seen !== want)
    begin
      fails++;
      $display("FAIL %0t seen %h want %h", $time, seen, want);
    end
  endtask : check
  task automatic wrap_up();
    $display("mismatches %0d checks %0d", fails, n_tests);
    if (fails == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : wrap_up
  // outputs are looked at mid-cycle, away from the edge that launches them
  always @(negedge i_clk)
  begin
    if (i_rst_b && o_phase === PH_Q4 && o_fetch === 1'b1 && pq.size() > 0)
      check(o_pc, pq.pop_front());
    if (i_rst_b && o_mem_wr === 1'b1 && wq.size() > 0)
      check({o_mem_addr, o_wr_data}, wq.pop_front());
  end
  initial
  begin
    void'($urandom(32'h1d04));
    i_rd_data = 8'($urandom);
    i_bank_select_register = 4'($urandom);
    // zero clear takes the nonzero branch, overflow set leaves the other untaken
    pq = '{0, 8, 10, 12, 14, 2, 4, 6};
    wq.push_back({i_bank_select_register, 8'h34, i_rd_data | 8'h20});
    wq.push_back({12'hf70, i_rd_data | 8'h01});
    wq.push_back({12'h010, i_rd_data | 8'h80});
    repeat (20) @(negedge i_clk);
    i_rst_b = 1;
    repeat (200) @(negedge i_clk) if (pq.size() + wq.size() == 0) break;
    check(pq.size() + wq.size(), 0);
    // mid-run reset with both flags flipped: nonzero falls through, no-overflow jumps
    i_rst_b   = 0;
    i_ovf     = 0;
    i_zero    = 1;
    i_rd_data = 8'($urandom);
    pq = '{0, 2, 4, 6, 8, 20};
    wq.push_back({12'h010, i_rd_data | 8'h80});
    repeat (3) @(negedge i_clk);
    i_rst_b = 1;
    repeat (200) @(negedge i_clk) if (pq.size() + wq.size() == 0) break;
    check(pq.size() + wq.size(), 0);
    wrap_up();
  end
  initial
  begin
    #20us;
    fails++;
    wrap_up();
  end
endmodule : test_relative_branch_and_bit_set_decode
`default_nettype wire
